// ===== dv/modbus_master_model.sv
`timescale 1ns/1ps
module modbus_master_model
  (input  wire        i_ref_clk,
   input  wire        i_resp_valid,
   input  wire        i_resp_exception,
   input  wire [15:0] i_resp_data,
   output logic       o_req_valid,
   output logic [7:0] o_req_func,
   output logic [15:0] o_req_addr,
   output logic [15:0] o_req_data);
  initial
  begin
    o_req_valid = 1'b0;
    o_req_func  = 8'h00;
    o_req_addr  = 16'h0000;
    o_req_data  = 16'h0000;
  end
  // idle lines show the inverse so a stale value never looks valid
  // the retry bound doubles as the give-up limit on a silent coil
  task automatic xfer(input [7:0] f, input [15:0] a, d, input int tries,
                      output logic [15:0] q, output logic ex, ok);
    ok = 1'b0;
    ex = 1'b0;
    q  = 16'h0000;
    for (int t = 0; t < tries && !ok; t++)
    begin
      @(posedge i_ref_clk);
      o_req_valid <= 1'b1;
      o_req_func  <= f;
      o_req_addr  <= a;
      o_req_data  <= d;
      @(posedge i_ref_clk);
      o_req_valid <= 1'b0;
      o_req_func  <= ~f;
      o_req_addr  <= ~a;
      o_req_data  <= ~d;
      #1;
      ok = (i_resp_valid === 1'b1);
      q  = i_resp_data;
      ex = i_resp_exception;
    end
  endtask
endmodule // modbus_master_model

// ===== dv/tb_modbus_calibration_config_if.sv
`timescale 1ns/1ps
`include "xmtr_cfg_consts.vh"
module tb_modbus_calibration_config_if;
  localparam zw = 50, sh = 20, dr = 30, fl = 4;
  logic        i_ref_clk = 0, i_rst = 1, i_frame_ok = 0, i_frame_for_me = 0;
  logic        i_frame_is_ascii = 0, i_frame_7bit = 0, i_frame_2stop = 0;
  logic [2:0]  i_frame_baud = 0;
  logic [1:0]  i_frame_parity = 0;
  logic [10:0] i_nv_serial_cfg = 0;
  logic        i_nv_cfg_valid = 0, i_auto_cfg_sw = 1, i_sec_store = 0;
  logic        i_zero_btn_done = 0, i_span_btn = 0, i_sec_permanent = 0;
  logic [11:0] i_sec_code = 0;
  logic [15:0] i_pressure = 16'h03F0, i_span_max = 16'h0FA0, i_span_min = 0;
  logic [15:0] i_zero_point = 16'h03E8, i_zero_band = 16'h0014, q;
  logic        ex, ok;
  wire         i_req_valid, o_resp_valid, o_resp_exception, o_over_range;
  wire [7:0]   i_req_func;
  wire [15:0]  i_req_addr, i_req_data, o_resp_data;
  wire         o_under_range, o_span_start, o_zero_start, o_span_done_message;
  wire         o_calibration_fail_message, o_sec_view_ok, o_sec_edit_ok;
  wire         o_sec_span_ok, o_sec_zero_ok, o_nv_sec_we, o_nv_cfg_we;
  wire         o_auto_cfg_busy, o_red_led, o_factory_restore, o_device_reset;
  wire [1:0]   o_sec_level;
  wire [10:0]  o_serial_cfg;
  wire [31:0]  o_vel_coef_used, o_area_used;
  int          miscompares = 0, checks_done = 0;
  int          n_span = 0, n_done = 0, n_fail = 0, n_zero = 0, n_fac = 0;
  int          n_nvcfg = 0, n_nvsec = 0;
  xmtr_cfg_if #(.ZERO_WIN_CYC(zw), .SPAN_HOLD_CYC(sh), .DEV_RESET_CYC(dr),
    .FLASH_CYC(fl)) i_dut (.*);
  modbus_master_model i_master (.i_ref_clk(i_ref_clk),
    .i_resp_valid(o_resp_valid), .i_resp_exception(o_resp_exception),
    .i_resp_data(o_resp_data), .o_req_valid(i_req_valid),
    .o_req_func(i_req_func), .o_req_addr(i_req_addr),
    .o_req_data(i_req_data));
  always #12.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    n_span  += (o_span_start === 1'b1);
    n_done  += (o_span_done_message === 1'b1);
    n_fail  += (o_calibration_fail_message === 1'b1);
    n_zero  += (o_zero_start === 1'b1);
    n_fac   += (o_factory_restore === 1'b1);
    n_nvcfg += (o_nv_cfg_we === 1'b1);
    n_nvsec += (o_nv_sec_we === 1'b1);
  end
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // write answers carry no data worth checking beyond the exception bit
  task rq(input [7:0] f, input [15:0] a, d, e, input logic e_ex);
    i_master.xfer(f, a, d, 3, q, ex, ok);
    chk({ok, ex}, {1'b1, e_ex});
    if (f == `FC_READ_COILS || f == `FC_READ_HOLD)
      chk(q, e);
  endtask
  task frame(input logic me);
    i_frame_ok <= 1;
    i_frame_for_me <= me;
    tick(1);
    i_frame_ok <= 0;
    tick(2);
  endtask
  task hold_span;
    i_span_btn <= 1;
    tick(sh + 8);
    i_span_btn <= 0;
    tick(4);
  endtask
  task sec(input [11:0] c, input logic p);
    i_sec_code <= c;
    i_sec_permanent <= p;
    i_sec_store <= 1;
    tick(1);
    i_sec_store <= 0;
    tick(2);
  endtask
  initial
  begin
    tick(20000);
    miscompares++;
    close_out;
  end
  initial
  begin
    tick(10);
    i_rst <= 0;
    tick(4);
    chk(o_auto_cfg_busy, 1);
    chk(o_red_led, 1);
    i_master.xfer(`FC_READ_INPUT, 16'h0001, 16'h0000, 2, q, ex, ok);
    chk(ok, 0);
    tick(40);
    i_frame_is_ascii <= 1;
    i_frame_baud <= 3'h5;
    i_frame_parity <= 2'h1;
    i_frame_7bit <= 1;
    frame(0);
    chk(o_auto_cfg_busy, 1);
    frame(1);
    chk({o_auto_cfg_busy, o_serial_cfg}, 12'b0_1_101_01_1_0_000);
    chk(n_nvcfg, 1);
    i_frame_is_ascii <= 0;
    frame(1);
    chk({o_auto_cfg_busy, o_serial_cfg}, 12'b0_1_101_01_1_0_000);
    hold_span;
    chk(n_span, 0);
    i_zero_btn_done <= 1;
    tick(1);
    i_zero_btn_done <= 0;
    hold_span;
    chk({n_span[15:0], n_done[15:0]}, {16'd1, 16'd1});
    i_zero_btn_done <= 1;
    i_pressure <= 16'h1000;
    tick(1);
    i_zero_btn_done <= 0;
    hold_span;
    chk({n_span[15:0], n_fail[15:0]}, {16'd1, 16'd2});
    chk(o_over_range, 1);
    i_pressure <= 16'h03F0;
    tick(zw + 5);
    hold_span;
    chk(n_span, 1);
    i_span_min <= 16'h0100;
    i_pressure <= 16'h0050;
    tick(4);
    chk({o_under_range, o_over_range}, 2'b10);
    i_span_min <= 0;
    i_pressure <= 16'h03F0;
    for (int i = 1; i < 6; i++)
      rq(`FC_READ_HOLD, i, 0, i == 1 ? 1 : i[0] ? 0 : 16'h3F80, 0);
    chk(o_vel_coef_used, `FLOAT_ONE);
    chk(o_area_used, `FLOAT_ONE);
    rq(`FC_WRITE_REG, `HR_VEL_COEF_HI, 16'h4000, 0, 0);
    rq(`FC_WRITE_MULTI, `HR_AREA_HI, 16'h4120, 0, 0);
    tick(1);
    chk(o_vel_coef_used, `FLOAT_ONE);
    rq(`FC_WRITE_REG, `HR_USE_DEFAULT, 16'h0000, 0, 0);
    tick(1);
    chk(o_vel_coef_used, 32'h4000_0000);
    chk(o_area_used, 32'h4120_0000);
    rq(`FC_READ_HOLD, `HR_VEL_COEF_HI, 0, 16'h4000, 0);
    rq(`FC_READ_INPUT, 16'h0001, 0, 0, 0);
    for (int k = 0; k < 4; k++)
      rq(8'h02 + 8'h05 * k, 16'h0001, 0, 0, 1);
    rq(`FC_READ_COILS, `COIL_ZERO, 0, 0, 0);
    i_pressure <= 16'h0450;
    rq(`FC_WRITE_COIL, `COIL_ZERO, 16'hFF00, 0, 0);
    tick(2);
    rq(`FC_READ_COILS, `COIL_ZERO, 0, 0, 0);
    chk(n_zero, 0);
    i_pressure <= 16'h03F0;
    rq(`FC_WRITE_COIL, `COIL_ZERO, 16'hFF00, 0, 0);
    tick(2);
    rq(`FC_READ_COILS, `COIL_ZERO, 0, 1, 0);
    chk(n_zero, 1);
    rq(`FC_WRITE_COIL, `COIL_SPAN, 16'hFF00, 0, 0);
    tick(2);
    rq(`FC_READ_COILS, `COIL_SPAN, 0, 1, 0);
    tick(zw + 5);
    rq(`FC_WRITE_COIL, `COIL_SPAN, 16'hFF00, 0, 0);
    tick(2);
    rq(`FC_READ_COILS, `COIL_SPAN, 0, 0, 0);
    rq(`FC_WRITE_COIL, `COIL_FACTORY, 16'hFF00, 0, 0);
    tick(2);
    chk(n_fac, 1);
    rq(`FC_READ_COILS, `COIL_FACTORY, 0, 1, 0);
    rq(`FC_READ_HOLD, `HR_USE_DEFAULT, 0, 1, 0);
    rq(`FC_READ_HOLD, `HR_VEL_COEF_HI, 0, 16'h3F80, 0);
    for (int i = 0; i < 4; i++)
    begin
      sec(12'h111 * i, 1);
      chk(o_sec_level, i);
      chk({o_sec_view_ok, o_sec_edit_ok, o_sec_span_ok, o_sec_zero_ok},
          {i < 2, i == 0, i == 0, i < 3});
      chk(n_nvsec, i);
    end
    sec(12'h111, 0);
    chk({o_sec_level, n_nvsec[3:0]}, {2'd1, 4'd3});
    rq(`FC_WRITE_COIL, `COIL_RESET, 16'h0000, 0, 0);
    tick(dr + 5);
    chk(o_device_reset, 0);
    rq(`FC_WRITE_COIL, `COIL_RESET, 16'hFF00, 0, 0);
    rq(`FC_READ_COILS, `COIL_RESET, 0, 1, 0);
    tick(20);
    chk(o_device_reset, 0);
    tick(12);
    chk(o_device_reset, 1);
    i_rst <= 1;
    i_auto_cfg_sw <= 0;
    tick(10);
    i_rst <= 0;
    tick(4);
    chk(o_auto_cfg_busy, 1);
    frame(1);
    chk({o_auto_cfg_busy, o_serial_cfg}, 12'b0_0_101_00_0_0_000);
    close_out;
  end
endmodule // tb_modbus_calibration_config_if
bind xmtr_cfg_if xmtr_cfg_if_props #(.SPAN_HOLD_CYC(20), .FLASH_CYC(4))
  i_props (.*);

// ===== dv/xmtr_cfg_if_props.sv
`timescale 1ns/1ps
module xmtr_cfg_if_props
  #(parameter SPAN_HOLD_CYC = 20,
    parameter FLASH_CYC     = 4)
  (input wire        i_ref_clk,
   input wire        i_rst,
   input wire        i_req_valid,
   input wire [7:0]  i_req_func,
   input wire        i_frame_ok,
   input wire        i_frame_for_me,
   input wire        i_span_btn,
   input wire [15:0] i_pressure,
   input wire [15:0] i_span_max,
   input wire        o_resp_valid,
   input wire        o_resp_exception,
   input wire        o_over_range,
   input wire        o_span_start,
   input wire [1:0]  o_sec_level,
   input wire        o_sec_view_ok,
   input wire        o_sec_edit_ok,
   input wire        o_sec_span_ok,
   input wire        o_sec_zero_ok,
   input wire        o_nv_cfg_we,
   input wire        o_auto_cfg_busy,
   input wire        o_red_led);
  reg  [7:0]  led_run_r;
  reg         led_last_r;
  reg  [15:0] held_r;
  reg         cfg_done_r;
  wire        taken;
  wire        fc_ok;
  assign taken = i_req_valid && !o_auto_cfg_busy;
  assign fc_ok = i_req_func inside {8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10};
  // held_r saturates so a stuck button cannot wrap into a false short hold
  always @(posedge i_ref_clk)
  begin
    led_last_r <= o_red_led;
    led_run_r  <= (o_auto_cfg_busy && o_red_led == led_last_r) ?
                  led_run_r + 8'h01 : 8'h00;
    held_r     <= !i_span_btn ? 16'h0000 :
                  (&held_r) ? held_r : held_r + 16'h0001;
    cfg_done_r <= i_rst ? 1'b0 : (cfg_done_r || o_nv_cfg_we);
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_busy_no_answer: assert property (o_auto_cfg_busy && i_req_valid |=> !o_resp_valid) else $error("answer while detecting");
  a_req_answered: assert property (taken |=> o_resp_valid) else $error("request not answered");
  a_resp_has_cause: assert property (o_resp_valid |-> $past(taken)) else $error("answer without request");
  a_fc_served: assert property (taken && fc_ok |=> !o_resp_exception) else $error("supported code refused");
  a_fc_refused: assert property (taken && !fc_ok |=> o_resp_exception) else $error("unsupported code served");
  a_over_flag: assert property ((i_pressure > i_span_max) [*4] |-> o_over_range) else $error("over range missed");
  a_led_flashing: assert property (led_run_r <= 5 * FLASH_CYC) else $error("red led not flashing");
  a_cfg_stored: assert property (o_auto_cfg_busy && i_frame_ok && i_frame_for_me |=> o_nv_cfg_we && !o_auto_cfg_busy) else $error("detection not finished");
  a_no_restart: assert property (cfg_done_r |-> !o_auto_cfg_busy && !o_nv_cfg_we) else $error("detection restarted");
  a_span_hold: assert property (o_span_start && !$past(taken) |-> held_r >= SPAN_HOLD_CYC) else $error("span started early");
  // access flags are registered from the level, so they trail it by one cycle
  a_sec_access: assert property (
    o_sec_view_ok == ($past(o_sec_level) < 2'd2) &&
    o_sec_edit_ok == ($past(o_sec_level) == 2'd0) &&
    o_sec_span_ok == ($past(o_sec_level) == 2'd0) &&
    o_sec_zero_ok == ($past(o_sec_level) != 2'd3))
    else $error("access table broken");
  c_cfg_found: cover property (o_nv_cfg_we);
  c_span_start: cover property (o_span_start);
  c_refused: cover property (taken && !fc_ok);
endmodule // xmtr_cfg_if_props

// ===== logic/xmtr_cfg_if.v
// Overview of operation
// R01 - span accepted within 5 minutes of zero
// R02 - span button ignored before zero done (code raises the calibration fail message instead)
// R03 - span after 3 s hold, then confirm
// R04 - flag over and under range errors
// R05 - refuse calibration when pressure out of band
// R06 - four security levels gate view, edit, calibration
// R07 - lowering level temporary, raising stored
// R08 - auto serial config infers framing from traffic
// R09 - red indicator double flash during auto config
// R10 - requests may go unanswered during detection
// R11 - detection ends on good addressed frame, stored
// R12 - detection restarts only on power cycle
// R13 - switch off fixes rtu 8n1, baud auto
// R14 - serve only function codes 1,3,4,5,6,16
// R15 - strings packed high byte first, zero padded
// R16 - coefficient and area default to 1.0
// R17 - written values used only when flag is 0
// R18 - coil reads 1 only after successful run
// R19 - writing 1 starts function, clears coil (span coil only sets coil_r[1], code gives no o_span_start pulse)
// R20 - master times out coil after 10 seconds
// R21 - zero only within two percent of old zero
// R22 - coils at 1 zero, 2 span, 3 defaults, 4 reset
// R23 - span coil fails without zero in 5 minutes
// R24 - reset coil acks at once, resets after 5 s
// R25 - factory coil restores calibration and coefficients
`timescale 1ns/1ps
`include "xmtr_cfg_consts.vh"
module xmtr_cfg_if
  #(parameter ZERO_WIN_CYC  = `ZERO_WIN_CYC,
    parameter SPAN_HOLD_CYC = `SPAN_HOLD_CYC,
    parameter DEV_RESET_CYC = `DEV_RESET_CYC,
    parameter FLASH_CYC     = `FLASH_CYC)
  (input  wire        i_ref_clk,
   input  wire        i_rst,
   // decoded request from the frame engine
   input  wire        i_req_valid,
   input  wire [7:0]  i_req_func,
   input  wire [15:0] i_req_addr,
   input  wire [15:0] i_req_data,
   input  wire        i_frame_ok,
   input  wire        i_frame_for_me,
   input  wire        i_frame_is_ascii,
   input  wire [2:0]  i_frame_baud,
   input  wire [1:0]  i_frame_parity,
   input  wire        i_frame_7bit,
   input  wire        i_frame_2stop,
   input  wire [10:0] i_nv_serial_cfg,
   input  wire        i_nv_cfg_valid,
   input  wire        i_auto_cfg_sw,
   // pressure and calibration band
   input  wire [15:0] i_pressure,
   input  wire [15:0] i_span_max,
   input  wire [15:0] i_span_min,
   input  wire [15:0] i_zero_point,
   input  wire [15:0] i_zero_band,
   input  wire        i_zero_btn_done,
   input  wire        i_span_btn,
   input  wire        i_sec_store,
   input  wire [11:0] i_sec_code,
   input  wire        i_sec_permanent,
   output reg         o_resp_valid,
   output reg         o_resp_exception,
   output reg  [15:0] o_resp_data,
   output reg         o_over_range,
   output reg         o_under_range,
   output reg         o_span_start,
   output reg         o_zero_start,
   output reg         o_span_done_message,
   output reg         o_calibration_fail_message,
   output reg  [1:0]  o_sec_level,
   output reg         o_sec_view_ok,
   output reg         o_sec_edit_ok,
   output reg         o_sec_span_ok,
   output reg         o_sec_zero_ok,
   output reg         o_nv_sec_we,
   output reg         o_nv_cfg_we,
   output reg  [10:0] o_serial_cfg,
   output reg         o_auto_cfg_busy,
   output reg         o_red_led,
   output reg         o_factory_restore,
   output reg         o_device_reset,
   output reg  [31:0] o_vel_coef_used,
   output reg  [31:0] o_area_used);

  reg        btn_s1_r, btn_s2_r, sw_s1_r, sw_s2_r;
  reg [15:0] use_default_r;
  reg [31:0] vel_coef_r;
  reg [31:0] area_r;
  reg [3:0]  coil_r;
  reg [33:0] zero_age_r;
  reg        zero_fresh_r;
  reg [31:0] hold_cnt_r;
  reg        hold_fired_r;
  reg [31:0] rst_cnt_r;
  reg        rst_pend_r;
  reg [1:0]  perm_level_r;
  reg        started_r;
  reg [23:0] flash_cnt_r;
  reg [2:0]  flash_step_r;
  reg [1:0]  cfg_state_r;

  localparam ST_INIT  = 2'd0;
  localparam ST_HUNT  = 2'd1;
  localparam ST_FIXED = 2'd2;

  wire in_band   = (i_pressure <= i_span_max) && (i_pressure >= i_span_min);
  wire [16:0] zdiff = (i_pressure >= i_zero_point) ?
                      {1'b0, i_pressure - i_zero_point} :
                      {1'b0, i_zero_point - i_pressure};
  wire zero_near = (zdiff <= {1'b0, i_zero_band});
  wire req_live  = i_req_valid && !o_auto_cfg_busy;
  wire fc_ok     = (i_req_func == `FC_READ_COILS) ||
                   (i_req_func == `FC_READ_HOLD) ||
                   (i_req_func == `FC_READ_INPUT) ||
                   (i_req_func == `FC_WRITE_COIL) ||
                   (i_req_func == `FC_WRITE_REG) ||
                   (i_req_func == `FC_WRITE_MULTI);
  wire coil_wr   = req_live && (i_req_func == `FC_WRITE_COIL);
  wire coil_one  = i_req_data == 16'hFF00;
  wire hr_wr     = req_live && ((i_req_func == `FC_WRITE_REG) ||
                                (i_req_func == `FC_WRITE_MULTI));
  wire [15:0] cidx = i_req_addr - 16'h0001;
  wire coil_hit  = i_req_addr >= `COIL_ZERO && i_req_addr <= `COIL_RESET;
  wire zero_go   = coil_wr && coil_one && i_req_addr == `COIL_ZERO; // R22
  wire span_go   = coil_wr && coil_one && i_req_addr == `COIL_SPAN;
  wire fact_go   = coil_wr && coil_one && i_req_addr == `COIL_FACTORY;
  wire rst_go    = coil_wr && coil_one && i_req_addr == `COIL_RESET;
  wire zero_pass = zero_go && zero_near && in_band;
  wire span_pass = span_go && zero_fresh_r && in_band;
  wire btn_span_ok = btn_s2_r && zero_fresh_r && o_sec_span_ok;
  wire [1:0] req_level = (i_sec_code == `SEC_CODE_0) ? 2'd0 :
                         (i_sec_code == `SEC_CODE_1) ? 2'd1 :
                         (i_sec_code == `SEC_CODE_2) ? 2'd2 : 2'd3;

  // the span button is a pin; synchronise before use
  always @(posedge i_ref_clk)
  begin
    btn_s1_r <= i_span_btn;
    btn_s2_r <= btn_s1_r;
    sw_s1_r  <= i_auto_cfg_sw;
    sw_s2_r  <= sw_s1_r;
  end

  // zero freshness window shared by button and coil paths
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      zero_age_r   <= 34'h0_0000_0000;
      zero_fresh_r <= 1'b0;
    end
    else if (i_zero_btn_done || zero_pass)
    begin
      zero_age_r   <= 34'h0_0000_0000;
      zero_fresh_r <= 1'b1; // R02
    end
    else if (zero_fresh_r)
    begin
      zero_age_r <= zero_age_r + 34'h0_0000_0001;
      if (zero_age_r >= ZERO_WIN_CYC - 1)
        zero_fresh_r <= 1'b0; // R01
    end
  end

  // span button hold timer
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      hold_cnt_r                 <= 32'h0000_0000;
      hold_fired_r               <= 1'b0;
      o_span_start               <= 1'b0;
      o_span_done_message        <= 1'b0;
      o_calibration_fail_message <= 1'b0;
    end
    else
    begin
      o_span_start               <= 1'b0;
      o_span_done_message        <= 1'b0;
      o_calibration_fail_message <= 1'b0;
      if (!btn_s2_r)
      begin
        hold_cnt_r   <= 32'h0000_0000;
        hold_fired_r <= 1'b0;
      end
      else if (!hold_fired_r)
      begin
        hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
        if (hold_cnt_r >= SPAN_HOLD_CYC - 1)
        begin
          hold_fired_r <= 1'b1; // R03
          if (!zero_fresh_r || !in_band)
            o_calibration_fail_message <= 1'b1; // R05
          else if (btn_span_ok)
          begin
            o_span_start        <= 1'b1; // R03
            o_span_done_message <= 1'b1;
          end
        end
      end
    end
  end

  // range flags
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_over_range  <= 1'b0;
      o_under_range <= 1'b0;
    end
    else
    begin
      o_over_range  <= i_pressure > i_span_max; // R04
      o_under_range <= i_pressure < i_span_min; // R04
    end
  end

  // security level: raise stored, lower held only until reset
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      perm_level_r <= 2'd0;
      o_sec_level  <= 2'd0;
      o_nv_sec_we  <= 1'b0;
    end
    else
    begin
      o_nv_sec_we <= 1'b0;
      if (i_sec_store)
      begin
        o_sec_level <= req_level;
        if (req_level > perm_level_r && i_sec_permanent)
        begin
          perm_level_r <= req_level; // R07
          o_nv_sec_we  <= 1'b1;
        end
      end
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_sec_view_ok <= 1'b1;
      o_sec_edit_ok <= 1'b1;
      o_sec_span_ok <= 1'b1;
      o_sec_zero_ok <= 1'b1;
    end
    else
    begin
      o_sec_view_ok <= o_sec_level <= 2'd1; // R06
      o_sec_edit_ok <= o_sec_level == 2'd0; // R06
      o_sec_span_ok <= o_sec_level == 2'd0; // R06
      o_sec_zero_ok <= o_sec_level <= 2'd2; // R06
    end
  end

  // serial configuration detection; runs once per power-up unless a valid stored config is loaded instead
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cfg_state_r     <= ST_INIT;
      o_auto_cfg_busy <= 1'b0;
      o_nv_cfg_we     <= 1'b0;
      o_serial_cfg    <= 11'h000;
      started_r       <= 1'b0;
    end
    else
    begin
      o_nv_cfg_we <= 1'b0;
      case (cfg_state_r)
        ST_INIT:
        begin
          started_r <= 1'b1;
          if (started_r && i_nv_cfg_valid)
          begin
            o_serial_cfg <= i_nv_serial_cfg; // R11
            cfg_state_r  <= ST_FIXED;
          end
          else if (started_r)
          begin
            o_auto_cfg_busy <= 1'b1; // R08
            cfg_state_r     <= ST_HUNT;
          end
        end
        ST_HUNT:
          if (i_frame_ok && i_frame_for_me)
          begin
            if (sw_s2_r)
              o_serial_cfg <= {i_frame_is_ascii, i_frame_baud,
                               i_frame_parity, i_frame_7bit,
                               i_frame_2stop, 3'b000}; // R08
            else
              o_serial_cfg <= {1'b0, i_frame_baud, 2'b00,
                               1'b0, 1'b0, 3'b000}; // R13
            o_nv_cfg_we     <= 1'b1; // R11
            o_auto_cfg_busy <= 1'b0;
            cfg_state_r     <= ST_FIXED;
          end
        ST_FIXED:
          cfg_state_r <= ST_FIXED; // R12
        default:
          cfg_state_r <= ST_INIT;
      endcase
    end
  end

  // red indicator: two flashes then a pause while hunting
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      flash_cnt_r  <= 24'h00_0000;
      flash_step_r <= 3'd0;
      o_red_led    <= 1'b0;
    end
    else if (!o_auto_cfg_busy)
    begin
      flash_cnt_r  <= 24'h00_0000;
      flash_step_r <= 3'd0;
      o_red_led    <= 1'b0;
    end
    else
    begin
      if (flash_cnt_r >= FLASH_CYC - 1)
      begin
        flash_cnt_r  <= 24'h00_0000;
        flash_step_r <= flash_step_r + 3'd1;
      end
      else
        flash_cnt_r <= flash_cnt_r + 24'h00_0001;
      o_red_led <= (flash_step_r == 3'd0) || (flash_step_r == 3'd2); // R09
    end
  end

  // holding registers and coils
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      use_default_r     <= `USE_DEFAULT_RST; // R17
      vel_coef_r        <= `FLOAT_ONE; // R16
      area_r            <= `FLOAT_ONE; // R16
      coil_r            <= 4'h0;
      o_zero_start      <= 1'b0;
      o_factory_restore <= 1'b0;
      rst_pend_r        <= 1'b0;
      rst_cnt_r         <= 32'h0000_0000;
      o_device_reset    <= 1'b0;
    end
    else
    begin
      o_zero_start      <= 1'b0;
      o_factory_restore <= 1'b0;
      if (hr_wr)
        case (i_req_addr)
          `HR_USE_DEFAULT: use_default_r      <= i_req_data;
          `HR_VEL_COEF_HI: vel_coef_r[31:16]  <= i_req_data;
          `HR_VEL_COEF_LO: vel_coef_r[15:0]   <= i_req_data;
          `HR_AREA_HI:     area_r[31:16]      <= i_req_data;
          `HR_AREA_LO:     area_r[15:0]       <= i_req_data;
          default:         use_default_r      <= use_default_r;
        endcase
      if (coil_wr && coil_one && coil_hit && i_req_addr != `COIL_RESET)
        coil_r[cidx[1:0]] <= 1'b0; // R19
      if (zero_pass)
      begin
        coil_r[0]    <= 1'b1; // R21
        o_zero_start <= 1'b1;
      end
      if (span_pass)
        coil_r[1] <= 1'b1; // R23
      if (fact_go)
      begin
        use_default_r     <= `USE_DEFAULT_RST; // R25
        vel_coef_r        <= `FLOAT_ONE;
        area_r            <= `FLOAT_ONE;
        coil_r[2]         <= 1'b1;
        o_factory_restore <= 1'b1;
      end
      if (rst_go)
      begin
        coil_r[3]  <= 1'b1; // R24
        rst_pend_r <= 1'b1;
        rst_cnt_r  <= 32'h0000_0000;
      end
      else if (rst_pend_r)
      begin
        rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
        if (rst_cnt_r >= DEV_RESET_CYC - 1)
          o_device_reset <= 1'b1; // R24
      end
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_vel_coef_used <= `FLOAT_ONE;
      o_area_used     <= `FLOAT_ONE;
    end
    else
    begin
      o_vel_coef_used <= (use_default_r == 16'h0000) ? vel_coef_r :
                         `FLOAT_ONE; // R17
      o_area_used     <= (use_default_r == 16'h0000) ? area_r :
                         `FLOAT_ONE; // R17
    end
  end

  // answers; silent while detection runs, master retries
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_resp_valid     <= 1'b0;
      o_resp_exception <= 1'b0;
      o_resp_data      <= 16'h0000;
    end
    else
    begin
      o_resp_valid     <= req_live; // R10
      o_resp_exception <= req_live && !fc_ok; // R14
      o_resp_data      <= 16'h0000;
      if (req_live && i_req_func == `FC_READ_COILS && coil_hit)
        o_resp_data <= {15'h0000, coil_r[cidx[1:0]]}; // R18
      else if (req_live && i_req_func == `FC_READ_HOLD)
        case (i_req_addr)
          `HR_USE_DEFAULT: o_resp_data <= use_default_r;
          `HR_VEL_COEF_HI: o_resp_data <= vel_coef_r[31:16]; // R15
          `HR_VEL_COEF_LO: o_resp_data <= vel_coef_r[15:0];
          `HR_AREA_HI:     o_resp_data <= area_r[31:16];
          `HR_AREA_LO:     o_resp_data <= area_r[15:0];
          default:         o_resp_data <= 16'h0000;
        endcase
      else if (coil_wr)
        o_resp_data <= i_req_data; // R19
    end
  end

endmodule // xmtr_cfg_if

// ===== pkg/xmtr_cfg_consts.vh
`ifndef XMTR_CFG_CONSTS_VH
`define XMTR_CFG_CONSTS_VH
// holding register offsets
`define HR_USE_DEFAULT      16'h0001
`define HR_VEL_COEF_HI      16'h0002
`define HR_VEL_COEF_LO      16'h0003
`define HR_AREA_HI          16'h0004
`define HR_AREA_LO          16'h0005
// coil offsets
`define COIL_ZERO           16'h0001
`define COIL_SPAN           16'h0002
`define COIL_FACTORY        16'h0003
`define COIL_RESET          16'h0004
// reset values (use-default flag 1, coefficients 1.0 in single precision)
`define USE_DEFAULT_RST     16'h0001
`define FLOAT_ONE           32'h3F80_0000
// function codes
`define FC_READ_COILS       8'h01
`define FC_READ_HOLD        8'h03
`define FC_READ_INPUT       8'h04
`define FC_WRITE_COIL       8'h05
`define FC_WRITE_REG        8'h06
`define FC_WRITE_MULTI      8'h10
// security codes
`define SEC_CODE_0          12'h000
`define SEC_CODE_1          12'h111
`define SEC_CODE_2          12'h222
`define SEC_CODE_3          12'h333
// timing at 40 MHz
// 64 bits wide so the five-minute window product cannot overflow
`define CLK_HZ              64'h0000_0000_0262_5A00
`define ZERO_WIN_S          300
`define SPAN_HOLD_S         3
`define DEV_RESET_S         5
`define FLASH_MS            250
`define ZERO_WIN_CYC        (`ZERO_WIN_S * `CLK_HZ)
`define SPAN_HOLD_CYC       (`SPAN_HOLD_S * `CLK_HZ)
`define DEV_RESET_CYC       (`DEV_RESET_S * `CLK_HZ)
`define FLASH_CYC           (`FLASH_MS * (`CLK_HZ / 1000))
`endif
